// ===== pms_pkg.sv
// Package for the power, reset and low-power mode sequencer.
// Assumes a single 125 MHz core clock and synchronous inputs.
package pms_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned PMS_CLK_HZ = 125_000_000;
	localparam int unsigned PMS_WDT_IRQ_S = 2;
	localparam int unsigned PMS_WDT_RST_S = 4;
	localparam int unsigned PMS_WDT_IRQ_CYC = PMS_WDT_IRQ_S * PMS_CLK_HZ;
	localparam int unsigned PMS_WDT_RST_CYC = PMS_WDT_RST_S * PMS_CLK_HZ;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PMS_SEQ_OFF = 4'h1,
		PMS_SEQ_BUCK = 4'h2,
		PMS_SEQ_LDO = 4'h4,
		PMS_SEQ_RUN = 4'h8
	} pms_seq_t;

	typedef enum logic [5:0] {
		PMS_MODE_ACTIVE = 6'h01,
		PMS_MODE_IDLE = 6'h02,
		PMS_MODE_SLEEP = 6'h04,
		PMS_MODE_PWR_DOWN = 6'h08,
		PMS_MODE_EXT_DOWN = 6'h10,
		PMS_MODE_SHUT = 6'h20
	} pms_mode_t;

	localparam logic [1:0] PMS_CAUSE_NONE = 2'h0;
	localparam logic [1:0] PMS_CAUSE_TIMER = 2'h1;
	localparam logic [1:0] PMS_CAUSE_GPIO = 2'h2;

	typedef struct packed {
		pms_seq_t seq;
		pms_mode_t mode;
		logic [31:0] wdt_cnt;
		logic wdt_irq;
		logic [31:0] wake_cnt;
		logic [31:0] period;
		logic timed;
		logic woke_shut;
		logic [1:0] cause;
		logic dbg_en;
		logic locked;
	} pms_state_t;

	localparam pms_state_t PMS_STATE_RST = '{
		seq: PMS_SEQ_OFF, mode: PMS_MODE_ACTIVE, wdt_cnt: 32'h0, wdt_irq: 1'b0,
		wake_cnt: 32'h0, period: 32'h0, timed: 1'b0, woke_shut: 1'b0,
		cause: PMS_CAUSE_NONE, dbg_en: 1'b0, locked: 1'b0
	};

endpackage : pms_pkg

// ===== pms_sequencer.sv
// Power-on sequencing, low-power mode control, watchdog and debug lockout.
// Assumes all inputs are synchronous to clk; the low-power oscillator is
// seen as a one-cycle tick pulse, and regulator readiness as levels.
//
// Notes on behaviour
// - Buck regulator enabled before the LDOs.
// - Core reset held until LDOs report stable.
// - External reset honoured at any time.
// - Active mode: processor runs, all peripherals clocked.
// - Idle mode: processor halted, system keeps running.
// - Sleep: only slow oscillator runs; timer/GPIO wake.
// - Sleep: processor waits, bus clock stopped, gating.
// - Sleep keeps state and SRAM at lowered voltage.
// - Power-down sleep: radio off, RAM/registers kept.
// - Extended power-down: only RAM and control powered.
// - Deep shutdown: only GPIO domain alive.
// - Event-only shutdown wake keeps all clocks off.
// - Shutdown wake reinitialises but keeps wake status.
// - Watchdog interrupt after two seconds unserviced.
// - Watchdog resets whole device after four seconds.
// - Low-power reference accepts 32 kHz class clocks.
// - Mode changes only on firmware request, wake event or reset.
// - Debug memory access disabled at power-up.
// - Lockout keeps debug off, rejects raw reads.
// - Power-on reset sets every circuit known.
// - Brownout forces device back to the power-on reset state.
`timescale 1ns/1ns
module pms_sequencer #(
	parameter int unsigned WDT_IRQ_CYC = pms_pkg::PMS_WDT_IRQ_CYC,
	parameter int unsigned WDT_RST_CYC = pms_pkg::PMS_WDT_RST_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic supply_ok,
	input wire logic external_reset_n,
	input wire logic buck_ok,
	input wire logic ldo_ok,
	input wire logic osc_tick,
	input wire logic gpio_wake,
	input wire logic mode_req_valid,
	input wire pms_pkg::pms_mode_t mode_req,
	input wire logic mode_req_timed,
	input wire logic [31:0] wake_period,
	input wire logic wdt_service,
	input wire logic lockout_valid,
	input wire logic lockout_found,
	input wire logic dbg_unlock_req,
	output logic buck_en,
	output logic rf_ldo_en,
	output logic dig_ldo_en,
	output logic core_reset_n,
	output logic cpu_run,
	output logic cpu_wait_for_interrupt_state,
	output logic core_bus_clk_en,
	output logic periph_clk_en,
	output logic low_power_oscillator_en,
	output logic regulator_low_v,
	output logic radio_pwr_en,
	output logic core_pwr_en,
	output logic core_ret_en,
	output logic ram_pwr_en,
	output logic wake_req,
	output logic wdt_irq,
	output pms_pkg::pms_mode_t power_mode,
	output logic woke_from_shutdown,
	output logic [1:0] wake_cause,
	output logic dbg_mem_access_en,
	output logic raw_read_allow
);
	import pms_pkg::*;

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	// Release is synchronised so that no flop leaves reset on a different edge.
	logic [1:0] rst_sync_q;
	logic rst_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_q = rst_sync_q[1];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pms_state_t s_q;
	pms_state_t s_d;
	logic low_pwr;
	logic osc_on;
	logic expire;
	logic wake_ev;

	// Low-power modes leave only by a wake event or a reset, never by firmware.
	assign low_pwr = (s_q.mode == PMS_MODE_SLEEP) || (s_q.mode == PMS_MODE_PWR_DOWN) ||
		(s_q.mode == PMS_MODE_EXT_DOWN) || (s_q.mode == PMS_MODE_SHUT);
	// Untimed shutdown keeps every clock source off to save oscillator power.
	assign osc_on = !((s_q.mode == PMS_MODE_SHUT) && !s_q.timed);
	// A zero period disables the timer so a pure event wake never fires early.
	assign expire = low_pwr && osc_on && (s_q.period != 32'h0) &&
		(s_q.wake_cnt >= s_q.period);
	assign wake_ev = low_pwr && (gpio_wake || expire);

	// Next-state logic for sequencing, modes, watchdog, wake timer and lockout.
	always_comb begin
		s_d = s_q;
		case (s_q.seq)
			PMS_SEQ_OFF: begin
				if (supply_ok && s_q.mode != PMS_MODE_SHUT) begin
					s_d.seq = PMS_SEQ_BUCK;
				end
			end
			PMS_SEQ_BUCK: begin
				if (buck_ok) begin
					s_d.seq = PMS_SEQ_LDO;
				end
			end
			PMS_SEQ_LDO: begin
				if (ldo_ok) begin
					s_d.seq = PMS_SEQ_RUN;
				end
			end
			PMS_SEQ_RUN: begin
				// Firmware requests change mode only from active or idle.
				if (mode_req_valid && !low_pwr) begin
					s_d.mode = mode_req;
					s_d.timed = mode_req_timed;
					s_d.period = wake_period;
					s_d.wake_cnt = 32'h0;
					if (mode_req == PMS_MODE_SHUT) begin
						s_d.seq = PMS_SEQ_OFF;
					end
				end
				if (s_q.mode == PMS_MODE_ACTIVE || s_q.mode == PMS_MODE_IDLE) begin
					if (wdt_service) begin
						s_d.wdt_cnt = 32'h0;
						s_d.wdt_irq = 1'b0;
					end else begin
						s_d.wdt_cnt = s_q.wdt_cnt + 32'h1;
						if (s_q.wdt_cnt + 32'h1 >= WDT_IRQ_CYC) begin
							s_d.wdt_irq = 1'b1;
						end
					end
				end
				if (lockout_valid && lockout_found) begin
					s_d.locked = 1'b1;
					s_d.dbg_en = 1'b0;
				end else if (dbg_unlock_req && !s_q.locked) begin
					s_d.dbg_en = 1'b1;
				end
			end
			default: begin
				s_d = PMS_STATE_RST;
			end
		endcase
		// Timer counts oscillator ticks only while the oscillator is powered.
		if (low_pwr && osc_on && osc_tick && !expire) begin
			s_d.wake_cnt = s_q.wake_cnt + 32'h1;
		end
		if (wake_ev) begin
			s_d.mode = PMS_MODE_ACTIVE;
			s_d.wake_cnt = 32'h0;
			s_d.cause = gpio_wake ? PMS_CAUSE_GPIO : PMS_CAUSE_TIMER;
			if (s_q.mode == PMS_MODE_SHUT) begin
				// Full reinitialisation, but the wake record survives.
				s_d = PMS_STATE_RST;
				s_d.seq = PMS_SEQ_BUCK;
				s_d.woke_shut = 1'b1;
				s_d.cause = gpio_wake ? PMS_CAUSE_GPIO : PMS_CAUSE_TIMER;
			end
		end
		// Watchdog escalation, brownout and external reset all restart from scratch.
		if (s_q.wdt_cnt >= WDT_RST_CYC - 32'h1) begin
			s_d = PMS_STATE_RST;
		end
		if (!supply_ok) begin
			s_d = PMS_STATE_RST;
		end
		if (!external_reset_n) begin
			s_d = PMS_STATE_RST;
		end
	end

	// State register; asynchronous reset loads the power-on state.
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			s_q <= PMS_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Power, clock and retention controls decoded from sequence and mode.
	logic run;
	logic act;
	assign run = (s_q.seq == PMS_SEQ_RUN);
	assign act = run && (s_q.mode == PMS_MODE_ACTIVE || s_q.mode == PMS_MODE_IDLE);
	assign buck_en = (s_q.seq != PMS_SEQ_OFF);
	assign rf_ldo_en = (s_q.seq == PMS_SEQ_LDO) || run;
	assign dig_ldo_en = (s_q.seq == PMS_SEQ_LDO) || run;
	assign core_reset_n = run;
	assign cpu_run = run && (s_q.mode == PMS_MODE_ACTIVE);
	assign cpu_wait_for_interrupt_state = run && (s_q.mode == PMS_MODE_SLEEP);
	assign core_bus_clk_en = act;
	assign periph_clk_en = act;
	// The oscillator accepts any 32 kHz class source; it is only enabled here.
	assign low_power_oscillator_en = osc_on;
	assign regulator_low_v = run && (s_q.mode == PMS_MODE_SLEEP);
	assign radio_pwr_en = act || (run && s_q.mode == PMS_MODE_SLEEP);
	assign core_pwr_en = radio_pwr_en;
	assign core_ret_en = run && (s_q.mode == PMS_MODE_PWR_DOWN);
	assign ram_pwr_en = (s_q.mode != PMS_MODE_SHUT);
	assign wake_req = wake_ev;
	assign wdt_irq = s_q.wdt_irq;
	assign power_mode = s_q.mode;
	assign woke_from_shutdown = s_q.woke_shut;
	assign wake_cause = s_q.cause;
	assign dbg_mem_access_en = s_q.dbg_en;
	assign raw_read_allow = !s_q.locked;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_ldo_after_buck: assert property (@(posedge clk) disable iff (!rst_q)
		$rose(rf_ldo_en) |-> $past(buck_en) && $past(buck_ok))
		else $error("LDO enabled before buck was up.");
	chk_core_rst_hold: assert property (@(posedge clk) disable iff (!rst_q)
		$rose(core_reset_n) |-> $past(ldo_ok) && $past(dig_ldo_en))
		else $error("Core reset released before LDOs stable.");
	chk_ext_reset: assert property (@(posedge clk) disable iff (!rst_q)
		!external_reset_n |=> !buck_en && !core_reset_n && !dbg_mem_access_en)
		else $error("External reset not honoured.");
	chk_sleep_clocks: assert property (@(posedge clk) disable iff (!rst_q)
		cpu_wait_for_interrupt_state |-> !core_bus_clk_en && !periph_clk_en && regulator_low_v)
		else $error("Sleep left clocks running.");
	chk_shut_clocks: assert property (@(posedge clk) disable iff (!rst_q)
		(power_mode == PMS_MODE_SHUT) && !s_q.timed |-> !low_power_oscillator_en && !buck_en)
		else $error("Event-only shutdown left a clock on.");
	chk_shut_wake: assert property (@(posedge clk) disable iff (!rst_q)
		(power_mode == PMS_MODE_SHUT) && gpio_wake && supply_ok && external_reset_n
		|=> woke_from_shutdown && wake_cause == PMS_CAUSE_GPIO && buck_en && !core_reset_n)
		else $error("Shutdown wake record missing.");
	chk_wdt_irq_time: assert property (@(posedge clk) disable iff (!rst_q)
		$rose(wdt_irq) |-> s_q.wdt_cnt == WDT_IRQ_CYC)
		else $error("Watchdog interrupt at wrong count.");
	chk_wdt_bound: assert property (@(posedge clk) disable iff (!rst_q)
		s_q.wdt_cnt < WDT_RST_CYC)
		else $error("Watchdog passed its reset count.");
	chk_wdt_service: assert property (@(posedge clk) disable iff (!rst_q)
		wdt_service && act && external_reset_n && supply_ok |=> s_q.wdt_cnt == 32'h0 && !wdt_irq)
		else $error("Watchdog service did not restart count.");
	chk_brownout: assert property (@(posedge clk) disable iff (!rst_q)
		!supply_ok |=> !buck_en && !rf_ldo_en)
		else $error("Brownout did not shut down.");
	chk_lockout: assert property (@(posedge clk) disable iff (!rst_q)
		!raw_read_allow |-> !dbg_mem_access_en ##1 !dbg_mem_access_en)
		else $error("Debug enabled while locked.");
	chk_mode_hold: assert property (@(posedge clk) disable iff (!rst_q)
		!mode_req_valid && !wake_ev && external_reset_n && supply_ok && run
		&& s_q.wdt_cnt < WDT_RST_CYC - 32'h1 |=> $stable(power_mode))
		else $error("Mode changed without a request.");

endmodule : pms_sequencer

// ===== pms_rail_model.sv
// Regulator and low-power oscillator model facing the sequencer.
// Assumes the enables come from the sequencer and the bench sets the settle lag.
`timescale 1ns/1ns
module pms_rail_model (
	input wire logic clk,
	input wire logic [3:0] lag,
	input wire logic buck_en,
	input wire logic rf_ldo_en,
	input wire logic dig_ldo_en,
	input wire logic osc_en,
	output logic buck_ok,
	output logic ldo_ok,
	output logic osc_tick
);
	int bc = 0;
	int lc = 0;
	int tc = 0;

	// ----------------------------------------------------------------
	// Rails and oscillator
	// ----------------------------------------------------------------
	// A rail reports good only after lag cycles enabled, so slow rails are exercised too.
	always @(posedge clk) begin
		bc <= buck_en ? bc + 1 : 0;
		lc <= (rf_ldo_en && dig_ldo_en) ? lc + 1 : 0;
		buck_ok <= buck_en && bc >= lag;
		ldo_ok <= rf_ldo_en && dig_ldo_en && lc >= lag;
		tc <= osc_en ? (tc + 1) % 5 : 0;
		osc_tick <= osc_en && tc == 4;
	end
endmodule : pms_rail_model

// ===== test_pms_sequencer.sv
// Self-checking bench for the power and mode sequencer.
// Assumes the rail model is compiled first; clock 125 MHz, short watchdog counts.
`timescale 1ns/1ns
module test_pms_sequencer;
	import pms_pkg::*;
	localparam int IRQ = 20;
	localparam int RST = 40;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic supply_ok = 1'b0;
	logic external_reset_n = 1'b1;
	logic gpio_wake = 1'b0;
	logic mode_req_valid = 1'b0;
	pms_mode_t mode_req = PMS_MODE_ACTIVE;
	logic mode_req_timed = 1'b0;
	logic [31:0] wake_period = 32'h0;
	logic wdt_service = 1'b0;
	logic lockout_valid = 1'b0;
	logic lockout_found = 1'b0;
	logic dbg_unlock_req = 1'b0;
	logic [3:0] lag = 4'h0;
	logic buck_ok, ldo_ok, osc_tick, buck_en, rf_ldo_en, dig_ldo_en, core_reset_n, cpu_run;
	logic cpu_wait_for_interrupt_state, core_bus_clk_en, periph_clk_en, wake_req, wdt_irq;
	logic low_power_oscillator_en, regulator_low_v, radio_pwr_en, core_pwr_en, core_ret_en;
	logic ram_pwr_en, woke_from_shutdown, dbg_mem_access_en, raw_read_allow;
	logic [1:0] wake_cause;
	pms_mode_t power_mode, m;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int svc_cnt = 0;
	int svc_gap = 8;
	int last_svc = 0;
	int seed;
	int per;
	logic tm;

	pms_sequencer #(.WDT_IRQ_CYC(IRQ), .WDT_RST_CYC(RST)) pms_sequencer_inst (.clk, .rst_n,
		.supply_ok, .external_reset_n, .buck_ok, .ldo_ok, .osc_tick, .gpio_wake, .mode_req_valid,
		.mode_req, .mode_req_timed, .wake_period, .wdt_service, .lockout_valid, .lockout_found,
		.dbg_unlock_req, .buck_en, .rf_ldo_en, .dig_ldo_en, .core_reset_n, .cpu_run,
		.cpu_wait_for_interrupt_state, .core_bus_clk_en, .periph_clk_en, .low_power_oscillator_en,
		.regulator_low_v, .radio_pwr_en, .core_pwr_en, .core_ret_en, .ram_pwr_en, .wake_req,
		.wdt_irq, .power_mode, .woke_from_shutdown, .wake_cause, .dbg_mem_access_en,
		.raw_read_allow);

	pms_rail_model pms_rail_model_inst (.clk, .lag, .buck_en, .rf_ldo_en, .dig_ldo_en,
		.osc_en(low_power_oscillator_en), .buck_ok, .ldo_ok, .osc_tick);

	// ----------------------------------------------------------------
	// Clock, firmware stand-in and timeout
	// ----------------------------------------------------------------
	initial forever #4 clk = ~clk;

	// Services the watchdog every svc_gap cycles; a hang ends the run as a failure.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		svc_cnt <= svc_cnt + 1 >= svc_gap ? 0 : svc_cnt + 1;
		wdt_service <= svc_cnt + 1 >= svc_gap;
		if (wdt_service) begin
			last_svc <= cyc;
		end
		if (cyc == 30000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	function automatic logic pick(input int k);
		case (k)
			0: return buck_en;
			1: return core_reset_n;
			2: return wdt_irq;
			3: return ~core_reset_n;
			default: return power_mode === PMS_MODE_ACTIVE;
		endcase
	endfunction : pick

	// Bounded wait, sampled just after each edge so that edge's updates have landed.
	task automatic wait_sig(input int k, input int lim);
		int i;
		i = 0;
		while (pick(k) !== 1'b1 && i < lim) begin
			@(posedge clk);
			#1;
			i++;
		end
	endtask : wait_sig

	// One-cycle pulse: 0 unlock, 1 lockout, 2 wake event, 3 external reset, 4 brownout.
	task automatic pulse(input int k);
		@(posedge clk);
		{lockout_valid, lockout_found} <= {2{k == 1}};
		dbg_unlock_req <= k == 0;
		gpio_wake <= k == 2;
		external_reset_n <= k != 3;
		supply_ok <= k != 4;
		#1;
		check(wake_req, k == 2);
		@(posedge clk);
		{lockout_valid, lockout_found, dbg_unlock_req, gpio_wake} <= 4'h0;
		external_reset_n <= 1'b1;
		supply_ok <= 1'b1;
		#1;
	endtask : pulse

	task automatic go(input pms_mode_t t, input logic timed, input logic [31:0] p);
		@(posedge clk);
		mode_req_valid <= 1'b1;
		mode_req <= t;
		mode_req_timed <= timed;
		wake_period <= p;
		@(posedge clk);
		mode_req_valid <= 1'b0;
		#1;
		check(power_mode, t);
	endtask : go

	// Reference model of the outputs that each mode fixes.
	function automatic logic [7:0] model(input pms_mode_t t, input logic timed);
		case (t)
			PMS_MODE_IDLE: return 8'h01;
			PMS_MODE_SLEEP: return 8'h27;
			PMS_MODE_PWR_DOWN: return 8'h06;
			PMS_MODE_EXT_DOWN: return 8'h01;
			default: return {7'h0, timed};
		endcase
	endfunction : model

	function automatic logic [7:0] seen_v(input pms_mode_t t);
		case (t)
			PMS_MODE_IDLE: return {6'h0, cpu_run, periph_clk_en};
			PMS_MODE_SLEEP: return {1'b0, cpu_run, cpu_wait_for_interrupt_state, core_bus_clk_en,
				periph_clk_en, regulator_low_v, ram_pwr_en, low_power_oscillator_en};
			PMS_MODE_PWR_DOWN: return {3'h0, radio_pwr_en, core_pwr_en, core_ret_en, ram_pwr_en,
				cpu_run};
			PMS_MODE_EXT_DOWN: return {4'h0, radio_pwr_en, core_pwr_en, core_ret_en, ram_pwr_en};
			default: return {4'h0, radio_pwr_en, core_pwr_en, buck_en, low_power_oscillator_en};
		endcase
	endfunction : seen_v

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'hd64d;
		lag <= 4'({$random(seed)} % 8);
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		supply_ok <= 1'b1;
		wait_sig(0, 20);
		check(rf_ldo_en | dig_ldo_en, 0);
		check(core_reset_n, 0);
		wait_sig(1, 60);
		check({ldo_ok, cpu_run, periph_clk_en, core_bus_clk_en}, 4'hf);
		check(dbg_mem_access_en, 0);
		$display("test power-up done");
		for (int j = 0; j < 10; j++) begin
			m = pms_mode_t'(6'h02 << (j % 5));
			tm = j >= 5;
			per = 1 + {$random(seed)} % 4;
			go(m, tm, tm ? 32'(per) : 32'h0);
			check(seen_v(m), model(m, tm));
			if (m == PMS_MODE_IDLE) begin
				go(PMS_MODE_ACTIVE, 1'b0, 32'h0);
				check(cpu_run, 1);
			end else begin
				if (!tm) begin
					repeat (6) @(posedge clk);
					// A request made while in a low-power mode must be ignored.
					mode_req_valid <= 1'b1;
					mode_req <= PMS_MODE_IDLE;
					@(posedge clk);
					mode_req_valid <= 1'b0;
					#1;
					check(power_mode, m);
					pulse(2);
				end
				wait_sig(4, per * 5 + 30);
				check({power_mode, wake_cause}, {PMS_MODE_ACTIVE, tm ? 2'h1 : 2'h2});
				if (m == PMS_MODE_SHUT) begin
					check(woke_from_shutdown, 1);
					wait_sig(1, 60);
				end
			end
		end
		$display("test modes done");
		svc_gap = 15;
		repeat (60) @(posedge clk);
		#1;
		check({wdt_irq, core_reset_n}, 2'h1);
		svc_gap = 100000;
		wait_sig(2, 60);
		check((cyc - last_svc) inside {[IRQ - 2:IRQ + 3]}, 1);
		wait_sig(3, 60);
		check((cyc - last_svc) inside {[RST - 2:RST + 3]}, 1);
		svc_gap = 8;
		wait_sig(1, 80);
		$display("test watchdog done");
		pulse(0);
		check(dbg_mem_access_en, 1);
		pulse(1);
		check({dbg_mem_access_en, raw_read_allow}, 2'h0);
		pulse(0);
		check(dbg_mem_access_en, 0);
		$display("test lockout done");
		pulse(3);
		check({core_reset_n, buck_en, raw_read_allow, power_mode}, {3'h1, PMS_MODE_ACTIVE});
		wait_sig(1, 60);
		pulse(4);
		check({buck_en, core_reset_n}, 2'h0);
		$display("test resets done");
		complete_run();
	end
endmodule : test_pms_sequencer
